// ==== sfp_front_end.sv ====
// serial flash command front end: interface modes, write latch, power-down filter, protection
`timescale 1ns/10ps
module sfp_front_end (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        csnPin,
  input  wire logic        sclkPin,
  input  wire logic [3:0]  ioIn,
  output logic      [3:0]  ioOut,
  output logic      [3:0]  ioOe,
  output logic      [23:0] arrayRdAddr,
  input  wire logic [7:0]  arrayRdData,
  output logic             progStrobe,
  output logic      [23:0] progAddr,
  output logic      [7:0]  progData,
  output logic             eraseStrobe,
  output logic      [23:0] eraseAddr,
  output logic      [1:0]  eraseKind,
  output logic             writeEnableLatch,
  output logic             quadCommandMode,
  output logic             powerDownMode,
  output logic      [4:0]  protectLevel,
  output logic             protectInvert
);

  // ---------------- functions
  function automatic logic [23:0] shiftIn(input logic [23:0] sh, input logic [3:0] io,
                                          input logic [2:0] lanes);
    logic [23:0] r;
    r = {sh[22:0], io[0]};
    if (lanes == 3'h2) r = {sh[21:0], io[1:0]};
    if (lanes == 3'h4) r = {sh[19:0], io[3:0]};
    return r;
  endfunction

  function automatic logic isAddrCmd(input logic [7:0] o);
    return o == sfp_pkg::OPC_READ || o == sfp_pkg::OPC_FAST || o == sfp_pkg::OPC_DOUT ||
           o == sfp_pkg::OPC_QOUT || o == sfp_pkg::OPC_DIO || o == sfp_pkg::OPC_QIO ||
           o == sfp_pkg::OPC_QWORD || o == sfp_pkg::OPC_PROG || o == sfp_pkg::OPC_QPROG ||
           o == sfp_pkg::OPC_WIPE4K || o == sfp_pkg::OPC_WIPE32 || o == sfp_pkg::OPC_WIPE64;
  endfunction

  function automatic logic isRead(input logic [7:0] o);
    return o == sfp_pkg::OPC_READ || o == sfp_pkg::OPC_FAST || o == sfp_pkg::OPC_DOUT ||
           o == sfp_pkg::OPC_QOUT || o == sfp_pkg::OPC_DIO || o == sfp_pkg::OPC_QIO ||
           o == sfp_pkg::OPC_QWORD;
  endfunction

  function automatic logic isProg(input logic [7:0] o);
    return o == sfp_pkg::OPC_PROG || o == sfp_pkg::OPC_QPROG;
  endfunction

  function automatic logic [4:0] dummyFor(input logic [7:0] o);
    logic [4:0] d;
    d = 5'h00;
    if (o == sfp_pkg::OPC_FAST || o == sfp_pkg::OPC_DOUT || o == sfp_pkg::OPC_QOUT)
      d = sfp_pkg::DUMMY_FAST;
    if (o == sfp_pkg::OPC_DIO)   d = sfp_pkg::DUMMY_DIO;
    if (o == sfp_pkg::OPC_QIO)   d = sfp_pkg::DUMMY_QIO;
    if (o == sfp_pkg::OPC_QWORD) d = sfp_pkg::DUMMY_QWORD;
    return d;
  endfunction

  // lanes per phase; quad command mode forces four everywhere
  function automatic logic [2:0] lanesFor(input sfp_pkg::sfp_state_t st, input logic [7:0] o,
                                          input logic quad_command_mode);
    logic [2:0] l;
    l = 3'h1;
    if (st == sfp_pkg::ST_ADDR && o == sfp_pkg::OPC_DIO) l = 3'h2;
    if (st == sfp_pkg::ST_ADDR && (o == sfp_pkg::OPC_QIO || o == sfp_pkg::OPC_QWORD)) l = 3'h4;
    if ((st == sfp_pkg::ST_DIN || st == sfp_pkg::ST_DOUT) &&
        (o == sfp_pkg::OPC_DOUT || o == sfp_pkg::OPC_DIO)) l = 3'h2;
    if ((st == sfp_pkg::ST_DIN || st == sfp_pkg::ST_DOUT) &&
        (o == sfp_pkg::OPC_QOUT || o == sfp_pkg::OPC_QIO || o == sfp_pkg::OPC_QWORD ||
         o == sfp_pkg::OPC_QPROG)) l = 3'h4;
    if (quad_command_mode) l = 3'h4;
    return l;
  endfunction

  function automatic logic inProt(input logic [23:0] a, input logic [23:0] lo,
                                  input logic [23:0] hi, input logic none, input logic inv);
    logic hit;
    hit = !none && a >= lo && a <= hi;
    return inv ? !hit : hit;
  endfunction

  // ---------------- pins
  logic [5:0] pinS;
  sfp_pin_sync #(
    .W     (6),
    .RST_V (sfp_pkg::RST_PINS)
  ) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pinIn   ({ioIn, sclkPin, csnPin}),
    .pinOut  (pinS)
  );

  wire       csnS  = pinS[0];
  wire       sclkS = pinS[1];
  wire [3:0] ioS   = pinS[5:2];

  // ---------------- state
  sfp_pkg::sfp_state_t st_q, st_d;
  logic        sclkPrev_q;
  logic        csnPrev_q;
  logic [23:0] sh_q, sh_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [7:0]  opc_q, opc_d;
  logic [23:0] addr_q, addr_d;
  logic        allow_q, allow_d;
  logic        accepted_q, accepted_d;
  logic        addrDone_q, addrDone_d;
  logic [1:0]  nBytes_q, nBytes_d;
  logic [7:0]  stat0_q, stat0_d;
  logic [7:0]  stat1_q, stat1_d;
  logic [7:0]  outSh_q, outSh_d;
  logic [2:0]  outCnt_q, outCnt_d;
  logic        armed_q;
  logic        wel_q;
  logic        qpi_q;
  logic        pdn_q;
  logic [4:0]  level_q;
  logic        inv_q;
  logic [3:0]  ioOut_q, ioOut_d;
  logic [3:0]  ioOe_q, ioOe_d;
  logic        progStb_q, progStb_d;
  logic [23:0] progAddr_q, progAddr_d;
  logic [7:0]  progData_q, progData_d;
  logic        eraseStb_q;
  logic [23:0] eraseAddr_q;
  logic [1:0]  eraseKind_q;

  // idle level of the clock does not matter: only sampled edges inside the frame count
  wire rise     = sclkS & ~sclkPrev_q & ~csnS;
  wire fall     = ~sclkS & sclkPrev_q & ~csnS;
  wire frameEnd = csnS & ~csnPrev_q;

  wire [2:0]  lanes   = lanesFor(st_q, opc_q, qpi_q);
  wire [23:0] shNext  = shiftIn(sh_q, ioS, lanes);
  wire [4:0]  cntNext = cnt_q + {2'h0, lanes};
  wire [7:0]  opcNew  = shNext[7:0];
  // power-down filter: everything but release and the reset pair is dropped
  wire        pdnPass = !pdn_q || opcNew == sfp_pkg::OPC_RELEASE ||
                        opcNew == sfp_pkg::OPC_RSTEN || opcNew == sfp_pkg::OPC_RST;

  logic [23:0] pLo;
  logic [23:0] pHi;
  logic        pNone;
  logic        pAll;
  sfp_protect_decode u_dec (
    .protectLevel (level_q),
    .protLo       (pLo),
    .protHi       (pHi),
    .protNone     (pNone),
    .protAll      (pAll)
  );

  // protected intervals always touch an array end, so checking a unit's two ends suffices
  wire [23:0] unitMask = (opc_q == sfp_pkg::OPC_WIPE64) ? sfp_pkg::MASK_64K :
                         (opc_q == sfp_pkg::OPC_WIPE32) ? sfp_pkg::MASK_32K :
                         sfp_pkg::MASK_4K;
  wire [23:0] unitLo   = addr_q & ~unitMask;
  wire [23:0] unitHi   = addr_q | unitMask;
  wire        unitOk   = !inProt(unitLo, pLo, pHi, pNone, inv_q) &&
                         !inProt(unitHi, pLo, pHi, pNone, inv_q);
  wire        chipOk   = inv_q ? pAll : pNone;
  wire        addrOk   = !inProt(shNext, pLo, pHi, pNone, inv_q);

  wire [7:0]  byteNow  = (outCnt_q == 3'h0) ? arrayRdData : outSh_q;

  // ---------------- serial engine
  always_comb begin
    st_d       = st_q;
    sh_d       = sh_q;
    cnt_d      = cnt_q;
    opc_d      = opc_q;
    addr_d     = addr_q;
    allow_d    = allow_q;
    accepted_d = accepted_q;
    addrDone_d = addrDone_q;
    nBytes_d   = nBytes_q;
    stat0_d    = stat0_q;
    stat1_d    = stat1_q;
    outSh_d    = outSh_q;
    outCnt_d   = outCnt_q;
    ioOut_d    = ioOut_q;
    ioOe_d     = ioOe_q;
    progStb_d  = 1'b0;
    progAddr_d = progAddr_q;
    progData_d = progData_q;
    if (csnS) begin
      st_d       = sfp_pkg::ST_OPC;
      cnt_d      = 5'h00;
      outCnt_d   = 3'h0;
      ioOe_d     = 4'h0;
      if (frameEnd) begin
        accepted_d = 1'b0;
        addrDone_d = 1'b0;
        nBytes_d   = 2'h0;
      end
    end else if (rise) begin
      case (st_q)
        sfp_pkg::ST_OPC: begin
          sh_d  = shNext;
          cnt_d = cntNext;
          if (cntNext == sfp_pkg::OPC_BITS) begin
            opc_d      = opcNew;
            cnt_d      = 5'h00;
            accepted_d = pdnPass;
            if (!pdnPass) st_d = sfp_pkg::ST_IGNORE;
            else if (isAddrCmd(opcNew)) st_d = sfp_pkg::ST_ADDR;
            else if (opcNew == sfp_pkg::OPC_STATW) st_d = sfp_pkg::ST_DIN;
            else st_d = sfp_pkg::ST_IGNORE;
          end
        end
        sfp_pkg::ST_ADDR: begin
          sh_d  = shNext;
          cnt_d = cntNext;
          if (cntNext == sfp_pkg::ADDR_BITS) begin
            addr_d     = shNext;
            addrDone_d = 1'b1;
            cnt_d      = 5'h00;
            allow_d    = wel_q && addrOk;
            if (dummyFor(opc_q) != 5'h00) st_d = sfp_pkg::ST_DUMMY;
            else if (isRead(opc_q)) st_d = sfp_pkg::ST_DOUT;
            else if (isProg(opc_q)) st_d = sfp_pkg::ST_DIN;
            else st_d = sfp_pkg::ST_IGNORE;
          end
        end
        sfp_pkg::ST_DUMMY: begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q + 5'h01 == dummyFor(opc_q)) begin
            cnt_d = 5'h00;
            st_d  = sfp_pkg::ST_DOUT;
          end
        end
        sfp_pkg::ST_DIN: begin
          sh_d  = shNext;
          cnt_d = cntNext;
          if (cntNext == sfp_pkg::OPC_BITS) begin
            cnt_d = 5'h00;
            if (isProg(opc_q) && allow_q) begin
              progStb_d  = 1'b1;
              progAddr_d = addr_q;
              progData_d = shNext[7:0];
              addr_d     = {addr_q[23:8], addr_q[7:0] + 8'h01};
            end
            if (opc_q == sfp_pkg::OPC_STATW && nBytes_q == 2'h0) stat0_d = shNext[7:0];
            if (opc_q == sfp_pkg::OPC_STATW && nBytes_q == 2'h1) stat1_d = shNext[7:0];
            if (nBytes_q != 2'h3) nBytes_d = nBytes_q + 2'h1;
          end
        end
        sfp_pkg::ST_DOUT: begin
        end
        sfp_pkg::ST_IGNORE: begin
        end
        default: st_d = sfp_pkg::ST_IGNORE;
      endcase
    end else if (fall && st_q == sfp_pkg::ST_DOUT) begin
      // outputs change only on the falling edge; io3 or io1 carries the top bit
      outSh_d  = byteNow << lanes;
      outCnt_d = outCnt_q + lanes;
      if (outCnt_q == 3'h0) addr_d = addr_q + 24'h000001;
      case (lanes)
        3'h4: begin
          ioOut_d = byteNow[7:4];
          ioOe_d  = 4'hF;
        end
        3'h2: begin
          ioOut_d = {2'h0, byteNow[7:6]};
          ioOe_d  = 4'h3;
        end
        default: begin
          ioOut_d = {2'h0, byteNow[7], 1'b0};
          ioOe_d  = 4'h2;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q       <= sfp_pkg::ST_OPC;
      sclkPrev_q <= 1'b0;
      csnPrev_q  <= 1'b1;
      sh_q       <= 24'h000000;
      cnt_q      <= 5'h00;
      opc_q      <= 8'h00;
      addr_q     <= 24'h000000;
      allow_q    <= 1'b0;
      accepted_q <= 1'b0;
      addrDone_q <= 1'b0;
      nBytes_q   <= 2'h0;
      stat0_q    <= 8'h00;
      stat1_q    <= 8'h00;
      outSh_q    <= 8'h00;
      outCnt_q   <= 3'h0;
      ioOut_q    <= 4'h0;
      ioOe_q     <= 4'h0;
      progStb_q  <= 1'b0;
      progAddr_q <= 24'h000000;
      progData_q <= 8'h00;
    end else begin
      st_q       <= st_d;
      sclkPrev_q <= sclkS;
      csnPrev_q  <= csnS;
      sh_q       <= sh_d;
      cnt_q      <= cnt_d;
      opc_q      <= opc_d;
      addr_q     <= addr_d;
      allow_q    <= allow_d;
      accepted_q <= accepted_d;
      addrDone_q <= addrDone_d;
      nBytes_q   <= nBytes_d;
      stat0_q    <= stat0_d;
      stat1_q    <= stat1_d;
      outSh_q    <= outSh_d;
      outCnt_q   <= outCnt_d;
      ioOut_q    <= ioOut_d;
      ioOe_q     <= ioOe_d;
      progStb_q  <= progStb_d;
      progAddr_q <= progAddr_d;
      progData_q <= progData_d;
    end
  end

  // ---------------- command execution at the end of a frame
  wire ex       = frameEnd && accepted_q;
  wire isWipe   = opc_q == sfp_pkg::OPC_WIPE4K || opc_q == sfp_pkg::OPC_WIPE32 ||
                  opc_q == sfp_pkg::OPC_WIPE64;
  wire isChip   = opc_q == sfp_pkg::OPC_CHIP_A || opc_q == sfp_pkg::OPC_CHIP_B;
  wire doStatW  = ex && opc_q == sfp_pkg::OPC_STATW && wel_q && nBytes_q != 2'h0;
  wire doWipe   = ex && isWipe && wel_q && addrDone_q && unitOk;
  wire doChip   = ex && isChip && wel_q && chipOk;
  wire swReset  = ex && opc_q == sfp_pkg::OPC_RST && armed_q;
  wire welSet   = ex && opc_q == sfp_pkg::OPC_SET_WRITE_LATCH_CMD;
  wire welClr   = swReset || (ex && (opc_q == sfp_pkg::OPC_CLEAR_WRITE_LATCH_CMD || opc_q == sfp_pkg::OPC_STATW ||
                  isChip || opc_q == sfp_pkg::OPC_SECW || opc_q == sfp_pkg::OPC_SECP ||
                  ((isProg(opc_q) || isWipe) && addrDone_q)));
  wire [1:0] kindNow = isChip ? sfp_pkg::WIPE_CHIP :
                       (opc_q == sfp_pkg::OPC_WIPE64) ? sfp_pkg::WIPE_64K :
                       (opc_q == sfp_pkg::OPC_WIPE32) ? sfp_pkg::WIPE_32K : sfp_pkg::WIPE_4K;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wel_q       <= 1'b0;
      qpi_q       <= 1'b0;
      pdn_q       <= 1'b0;
      armed_q     <= 1'b0;
      level_q     <= sfp_pkg::RST_PROTECT;
      inv_q       <= sfp_pkg::RST_INVERT;
      eraseStb_q  <= 1'b0;
      eraseAddr_q <= 24'h000000;
      eraseKind_q <= sfp_pkg::WIPE_4K;
    end else begin
      if (welSet) wel_q <= 1'b1;
      else if (welClr) wel_q <= 1'b0;
      if (swReset || (ex && opc_q == sfp_pkg::OPC_QPI_OFF)) qpi_q <= 1'b0;
      else if (ex && opc_q == sfp_pkg::OPC_QPI_ON) qpi_q <= 1'b1;
      if (swReset || (ex && opc_q == sfp_pkg::OPC_RELEASE)) pdn_q <= 1'b0;
      else if (ex && opc_q == sfp_pkg::OPC_PDOWN) pdn_q <= 1'b1;
      if (ex) armed_q <= (opc_q == sfp_pkg::OPC_RSTEN);
      if (doStatW) level_q <= stat0_q[6:2];
      if (doStatW && nBytes_q != 2'h1) inv_q <= stat1_q[6];
      eraseStb_q <= doWipe || doChip;
      if (doWipe || doChip) begin
        eraseAddr_q <= isChip ? 24'h000000 : unitLo;
        eraseKind_q <= kindNow;
      end
    end
  end

  assign ioOut            = ioOut_q;
  assign ioOe             = ioOe_q;
  assign arrayRdAddr      = addr_q;
  assign progStrobe       = progStb_q;
  assign progAddr         = progAddr_q;
  assign progData         = progData_q;
  assign eraseStrobe      = eraseStb_q;
  assign eraseAddr        = eraseAddr_q;
  assign eraseKind        = eraseKind_q;
  assign writeEnableLatch = wel_q;
  assign quadCommandMode  = qpi_q;
  assign powerDownMode    = pdn_q;
  assign protectLevel     = level_q;
  assign protectInvert    = inv_q;

endmodule // sfp_front_end

// ==== sfp_front_end_properties.sv ====
// port assertions for the flash mode and protection front end
`timescale 1ns/10ps
module sfp_front_end_properties (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        csnPin,
  input wire logic [3:0]  ioOe,
  input wire logic        progStrobe,
  input wire logic        eraseStrobe,
  input wire logic [23:0] eraseAddr,
  input wire logic [1:0]  eraseKind,
  input wire logic        writeEnableLatch,
  input wire logic        quadCommandMode,
  input wire logic        powerDownMode,
  input wire logic [4:0]  protectLevel,
  input wire logic        protectInvert
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire allProt = protectInvert ? protectLevel[2:0] == 3'h0 : protectLevel[2:0] == 3'h7;
  wire noProt  = protectInvert ? protectLevel[2:0] == 3'h7 : protectLevel[2:0] == 3'h0;
  // six cycles covers the pin synchroniser plus the release cycle
  sequence deselected; csnPin [*6]; endsequence
  sequence asleep; powerDownMode [*2]; endsequence
  a_oe_idle_deselect: assert property (deselected |-> ioOe == 4'h0)
    else $error("pins driven while deselected");
  a_asleep_ignores: assert property (asleep |-> !eraseStrobe && !progStrobe
    && !$rose(writeEnableLatch) && !$rose(quadCommandMode))
    else $error("command obeyed in power-down");
  a_prog_needs_latch: assert property (progStrobe |-> writeEnableLatch)
    else $error("program without latch");
  a_prog_not_locked: assert property (progStrobe |-> !allProt)
    else $error("program into fully protected array");
  a_erase_clears_latch: assert property (eraseStrobe |-> $past(writeEnableLatch)
    && !writeEnableLatch) else $error("erase latch handling wrong");
  a_chip_needs_empty: assert property (eraseStrobe && eraseKind == sfp_pkg::WIPE_CHIP
    |-> noProt && eraseAddr == 24'h000000) else $error("chip erase with protection");
  a_sector_aligned: assert property (eraseStrobe && eraseKind == sfp_pkg::WIPE_4K
    |-> eraseAddr[11:0] == 12'h000 && !allProt) else $error("sector erase misaligned");
  a_quad_all_lanes: assert property (quadCommandMode |-> ioOe == 4'h0 || ioOe == 4'hF)
    else $error("partial lanes in quad command mode");
  a_acts_deselected: assert property ($changed(quadCommandMode)
    || $changed(writeEnableLatch) |-> csnPin) else $error("state changed inside frame");
endmodule // sfp_front_end_properties

bind sfp_front_end sfp_front_end_properties u_props (.sys_clk, .rstn, .csnPin, .ioOe,
  .progStrobe, .eraseStrobe, .eraseAddr, .eraseKind, .writeEnableLatch, .quadCommandMode,
  .powerDownMode, .protectLevel, .protectInvert);

// ==== sfp_front_end_tb.sv ====
// self-checking bench for the flash front end
`timescale 1ns/10ps
module sfp_front_end_tb;
  logic        sys_clk, rstn, csnPin, sclkPin, progStrobe, eraseStrobe, inv, bad;
  logic        writeEnableLatch, quadCommandMode, powerDownMode, protectInvert;
  logic [3:0]  ioIn, ioOut, ioOe;
  logic [23:0] arrayRdAddr, progAddr, eraseAddr, a, um;
  logic [7:0]  arrayRdData, progData, key, d, wop;
  logic [4:0]  protectLevel, lv;
  logic [1:0]  eraseKind, wk;
  logic [31:0] lastU;
  logic [19:0] rdOp [7];
  int          n_errors, checked, nStb, s0, seed, ol;
  assign arrayRdData = arrayRdAddr[7:0] ^ arrayRdAddr[15:8] ^ key;
  sfp_front_end u_dut (.sys_clk, .rstn, .csnPin, .sclkPin, .ioIn, .ioOut, .ioOe,
    .arrayRdAddr, .arrayRdData, .progStrobe, .progAddr, .progData, .eraseStrobe, .eraseAddr,
    .eraseKind, .writeEnableLatch, .quadCommandMode, .powerDownMode, .protectLevel,
    .protectInvert);
  sfp_host_model u_host (.sys_clk, .csnPin, .sclkPin, .ioIn, .ioOut, .ioOe);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (progStrobe === 1'b1 || eraseStrobe === 1'b1) begin
      nStb++;
      lastU <= eraseStrobe ? {eraseAddr, 6'h00, eraseKind} : {progAddr, progData};
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // base range from the level bits, then complement when inverted
  function automatic bit refused(input logic [4:0] l, input bit iv, input int a0, a1);
    int sz, lo, hi;
    sz = l[4] ? 'h1000 << (l[2:0] > 3 ? 3 : l[2:0] - 1) : 'h20000 << (l[2:0] - 1);
    lo = (l[3] || l[2:0] == 7) ? 0 : 'h800000 - sz;
    hi = l[2:0] == 7 ? 'h7FFFFF : lo + sz - 1;
    return iv ? (l[2:0] == 0 || a0 < lo || a1 > hi) : (l[2:0] != 0 && a1 >= lo && a0 <= hi);
  endfunction
  task automatic cmd(input logic [7:0] op);
    u_host.start();
    u_host.sendByte(op, ol);
    u_host.stop();
  endtask
  task automatic addrCmd(input logic [7:0] op, input logic [23:0] ad, input int al);
    u_host.start();
    u_host.sendByte(op, ol);
    for (int k = 2; k >= 0; k--) u_host.sendByte(ad[k*8 +: 8], al);
  endtask
  initial begin
    repeat (80000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    seed = 32'h0716;
    rstn = 1'b0;
    ol = 1;
    key = 8'($random(seed));
    rdOp = '{20'h03101, 20'h0B181, 20'h3B182, 20'h6B184, 20'hBB242, 20'hEB464, 20'hE7444};
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk("latch", writeEnableLatch, 0);
    chk("quad mode", quadCommandMode, 0);
    chk("protect", {protectInvert, protectLevel}, 0);
    foreach (rdOp[j]) begin
      u_host.idleHi = j[0];
      a = $random(seed) & 24'h7FFFFE;
      addrCmd(rdOp[j][19:12], a, rdOp[j][11:8]);
      u_host.dummy(rdOp[j][7:4]);
      for (int b = 0; b < 2; b++) begin
        u_host.recvByte(rdOp[j][3:0], d);
        chk("read byte", d, 8'((a + b) ^ ((a + b) >> 8) ^ key));
      end
      u_host.stop();
    end
    for (int i = 0; i < 32; i++) begin
      lv = 5'(i);
      inv = lv[0] ^ lv[3];
      cmd(8'h06);
      u_host.start();
      u_host.sendByte(8'h01, 1);
      u_host.sendByte({1'b0, lv, 2'b00}, 1);
      u_host.sendByte({1'b0, inv, 6'h00}, 1);
      u_host.stop();
      chk("protect", {protectInvert, protectLevel}, {inv, lv});
      a = $random(seed) & (lv[2] ? 24'h00FFFF : 24'h7FFFFF);
      a = lv[1] ? a | 24'h7F0000 : a;
      d = 8'($random(seed));
      wk = 2'($random(seed)) % 2'h3;
      wop = wk == 2'h0 ? 8'h20 : wk == 2'h1 ? 8'h52 : 8'hD8;
      um = !lv[0] ? 24'h000000 : wk == 2'h0 ? 24'h000FFF : wk == 2'h1 ? 24'h007FFF : 24'h00FFFF;
      s0 = nStb;
      cmd(8'h06);
      addrCmd(lv[0] ? wop : lv[3] ? 8'h32 : 8'h02, a, 1);
      if (!lv[0]) u_host.sendByte(d, lv[3] ? 4 : 1);
      u_host.stop();
      bad = refused(lv, inv, a & ~um, a | um);
      chk("unit strobes", nStb - s0, !bad);
      if (!bad) chk("unit", lastU, lv[0] ? {a & ~um, 6'h00, wk} : {a, d});
      chk("latch", writeEnableLatch, 0);
      s0 = nStb;
      cmd(8'h06);
      cmd(lv[1] ? 8'hC7 : 8'h60);
      bad = refused(lv, inv, 0, 'h7FFFFF);
      chk("chip wipe", nStb - s0, !bad);
      if (!bad) chk("chip unit", lastU, 32'h00000003);
    end
    cmd(8'hB9);
    cmd(8'h06);
    chk("asleep", {powerDownMode, writeEnableLatch}, 2'b10);
    cmd(8'hAB);
    cmd(8'h06);
    chk("awake", {powerDownMode, writeEnableLatch}, 2'b01);
    cmd(8'h04);
    chk("latch off", writeEnableLatch, 0);
    cmd(8'h06);
    cmd(8'h44);
    chk("sec wipe", writeEnableLatch, 0);
    cmd(8'h06);
    cmd(8'h42);
    chk("sec prog", writeEnableLatch, 0);
    cmd(8'h38);
    ol = 4;
    cmd(8'h06);
    chk("quad latch", {quadCommandMode, writeEnableLatch}, 2'b11);
    addrCmd(8'h03, a, 4);
    u_host.recvByte(4, d);
    u_host.stop();
    chk("quad cmd read", d, 8'(a ^ (a >> 8) ^ key));
    cmd(8'hFF);
    ol = 1;
    chk("spi again", quadCommandMode, 0);
    cmd(8'h38);
    ol = 4;
    cmd(8'h66);
    cmd(8'h99);
    ol = 1;
    chk("soft reset", quadCommandMode, 0);
    tally_and_finish();
  end
endmodule // sfp_front_end_tb

// ==== sfp_host_model.sv ====
// host controller model driving the serial flash pins
`timescale 1ns/10ps
module sfp_host_model (
  input  wire logic       sys_clk,
  output logic            csnPin,
  output logic            sclkPin,
  output logic      [3:0] ioIn,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOe
);
  logic [3:0] hv;
  logic       idleHi;
  // released lines toggle so a stale value never reads as valid
  assign ioIn = (ioOe & ioOut) | (~ioOe & hv);
  initial begin
    csnPin = 1'b1;
    sclkPin = 1'b0;
    hv = 4'h0;
    idleHi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic pulse(input logic [3:0] v, output logic [3:0] r);
    hv <= v;
    sclkPin <= 1'b0;
    tick(6);
    sclkPin <= 1'b1;
    tick(6);
    r = ioIn;
  endtask
  task automatic sendByte(input logic [7:0] b, input int lanes);
    logic [3:0] r;
    for (int k = 0; k < 8 / lanes; k++) begin
      pulse(4'(b >> (8 - lanes)), r);
      b = b << lanes;
    end
  endtask
  task automatic recvByte(input int lanes, output logic [7:0] b);
    logic [3:0] r;
    b = 8'h00;
    for (int k = 0; k < 8 / lanes; k++) begin
      pulse(~hv, r);
      b = (b << lanes) | (lanes == 1 ? 8'(r[1]) : 8'(r & 4'((1 << lanes) - 1)));
    end
  endtask
  task automatic dummy(input int n);
    logic [3:0] r;
    repeat (n) pulse(~hv, r);
  endtask
  task automatic start();
    sclkPin <= idleHi;
    tick(6);
    csnPin <= 1'b0;
    tick(6);
  endtask
  task automatic stop();
    sclkPin <= idleHi;
    tick(6);
    csnPin <= 1'b1;
    hv <= ~hv;
    tick(10);
  endtask
endmodule // sfp_host_model

// ==== sfp_pin_sync.sv ====
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module sfp_pin_sync #(
  parameter int         W      = 6,
  parameter logic [5:0] RST_V  = 6'h01
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q  <= RST_V[W-1:0];
      s2_q  <= RST_V[W-1:0];
      s3_q  <= RST_V[W-1:0];
      out_q <= RST_V[W-1:0];
    end else begin
      s1_q  <= pinIn;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= (agree & s3_q) | (~agree & out_q);
    end
  end

  assign pinOut = out_q;

endmodule // sfp_pin_sync

// ==== sfp_pkg.sv ====
// shared constants and types for the serial flash mode and protection front end
package sfp_pkg;

  localparam int ADDR_W = 24;

  // array layout: block field and sector field positions in the byte address
  localparam int BLK_MSB = 22;
  localparam int BLK_LSB = 16;
  localparam int SEC_MSB = 15;
  localparam int SEC_LSB = 12;

  localparam logic [23:0] ARRAY_TOP = 24'h7FFFFF;
  localparam logic [23:0] MASK_4K   = 24'h000FFF;
  localparam logic [23:0] MASK_32K  = 24'h007FFF;
  localparam logic [23:0] MASK_64K  = 24'h00FFFF;
  localparam logic [23:0] SIZE_4K   = 24'h001000;
  localparam logic [23:0] SIZE_128K = 24'h020000;

  // bit counts per phase
  localparam logic [4:0] OPC_BITS  = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;

  // dummy clocks per read command
  localparam logic [4:0] DUMMY_FAST  = 5'h08;
  localparam logic [4:0] DUMMY_DIO   = 5'h04;
  localparam logic [4:0] DUMMY_QIO   = 5'h06;
  localparam logic [4:0] DUMMY_QWORD = 5'h04;

  // values after reset
  localparam logic [4:0] RST_PROTECT = 5'h00;
  localparam logic       RST_INVERT  = 1'b0;
  localparam logic [5:0] RST_PINS    = 6'h01;

  // opcodes
  localparam logic [7:0] OPC_SET_WRITE_LATCH_CMD   = 8'h06;
  localparam logic [7:0] OPC_CLEAR_WRITE_LATCH_CMD   = 8'h04;
  localparam logic [7:0] OPC_STATW  = 8'h01;
  localparam logic [7:0] OPC_READ   = 8'h03;
  localparam logic [7:0] OPC_FAST   = 8'h0B;
  localparam logic [7:0] OPC_DOUT   = 8'h3B;
  localparam logic [7:0] OPC_QOUT   = 8'h6B;
  localparam logic [7:0] OPC_DIO    = 8'hBB;
  localparam logic [7:0] OPC_QIO    = 8'hEB;
  localparam logic [7:0] OPC_QWORD  = 8'hE7;
  localparam logic [7:0] OPC_PROG   = 8'h02;
  localparam logic [7:0] OPC_QPROG  = 8'h32;
  localparam logic [7:0] OPC_WIPE4K = 8'h20;
  localparam logic [7:0] OPC_WIPE32 = 8'h52;
  localparam logic [7:0] OPC_WIPE64 = 8'hD8;
  localparam logic [7:0] OPC_CHIP_A = 8'h60;
  localparam logic [7:0] OPC_CHIP_B = 8'hC7;
  localparam logic [7:0] OPC_SECW   = 8'h44;
  localparam logic [7:0] OPC_SECP   = 8'h42;
  localparam logic [7:0] OPC_PDOWN  = 8'hB9;
  localparam logic [7:0] OPC_RELEASE = 8'hAB;
  localparam logic [7:0] OPC_RSTEN  = 8'h66;
  localparam logic [7:0] OPC_RST    = 8'h99;
  localparam logic [7:0] OPC_QPI_ON = 8'h38;
  localparam logic [7:0] OPC_QPI_OFF = 8'hFF;

  // erase kinds reported with an erase strobe
  localparam logic [1:0] WIPE_4K   = 2'h0;
  localparam logic [1:0] WIPE_32K  = 2'h1;
  localparam logic [1:0] WIPE_64K  = 2'h2;
  localparam logic [1:0] WIPE_CHIP = 2'h3;

  typedef enum logic [2:0] {
    ST_OPC    = 3'b000,
    ST_ADDR   = 3'b001,
    ST_DUMMY  = 3'b010,
    ST_DIN    = 3'b011,
    ST_DOUT   = 3'b100,
    ST_IGNORE = 3'b101
  } sfp_state_t;

endpackage

// ==== sfp_protect_decode.sv ====
// decodes the protect level bits into a protected address interval
`timescale 1ns/10ps
module sfp_protect_decode (
  input  wire logic [4:0]  protectLevel,
  output logic      [23:0] protLo,
  output logic      [23:0] protHi,
  output logic             protNone,
  output logic             protAll
);

  wire [2:0]  low    = protectLevel[2:0];
  wire        fine   = protectLevel[4];
  wire        bottom = protectLevel[3];
  wire [2:0]  stepL  = low - 3'h1;
  wire [1:0]  stepS  = (stepL > 3'h3) ? 2'h3 : stepL[1:0];
  // large sizes double from 128 KB; fine sizes double from 4 KB and stop at 32 KB
  wire [23:0] bigSz  = sfp_pkg::SIZE_128K << stepL;
  wire [23:0] fineSz = sfp_pkg::SIZE_4K << stepS;
  wire [23:0] size   = fine ? fineSz : bigSz;

  assign protNone = (low == 3'h0);
  assign protAll  = (low == 3'h7);
  assign protLo = protAll ? 24'h000000 : (bottom ? 24'h000000 : sfp_pkg::ARRAY_TOP - size + 24'h000001);
  assign protHi = protAll ? sfp_pkg::ARRAY_TOP : (bottom ? size - 24'h000001 : sfp_pkg::ARRAY_TOP);

endmodule // sfp_protect_decode
